// ==== core/acr_cal_regs.sv ====
/*
 * Calibration register bank for channel 1 trims and the full channel 2
 * set, reached over APB, driving two correction pipelines and the
 * channel 2 front-end controls.
 * Assumes an APB master on pclk and samples arriving on pclk.
 */
`timescale 1ns/1ps
module acr_cal_regs (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [acr_pkg::ACR_ADDR_W-1:0] paddr,
   input wire logic [acr_pkg::ACR_DATA_W-1:0] pwdata,
   output logic [acr_pkg::ACR_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Global filter setting, nonzero enables the DC filter unless the channel 2 bypass bit is set
   input wire logic [3:0] global_dc_filter_setting,
   // Channel 1 samples
   input wire logic [acr_pkg::ACR_CAL_W-1:0] ch1_sample_data,
   input wire logic ch1_sample_valid,
   output logic [acr_pkg::ACR_CAL_W-1:0] ch1_corrected_data,
   output logic ch1_corrected_valid,
   // Channel 2 samples
   input wire logic [acr_pkg::ACR_CAL_W-1:0] ch2_sample_data,
   input wire logic ch2_sample_valid,
   output logic [acr_pkg::ACR_CAL_W-1:0] ch2_corrected_data,
   output logic ch2_corrected_valid,
   // Channel 2 front-end controls
   output logic [9:0] ch2_sample_delay,
   output logic ch2_dc_filter_bypass,
   output logic ch2_dc_filter_active,
   output logic [1:0] ch2_input_select
);
   import acr_pkg::*;

   typedef struct packed {
      logic [ACR_DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
      logic [9:0] sample_delay;
      logic dc_bypass;
      logic dc_active;
      logic [1:0] input_select;
   } acr_top_state_type;

   acr_top_state_type state_q;
   acr_top_state_type state_d;

   logic [ACR_REG_W-1:0] reg_value [ACR_NUM_REGS];
   logic [ACR_NUM_REGS-1:0] reg_wr_en;
   logic [9:0] req_index;
   logic [9:0] req_slot;
   logic req_aligned;
   logic req_hit;
   logic setup_phase;
   logic write_commit;

   logic [ACR_CAL_W-1:0] ch1_offset_word;
   logic [ACR_CAL_W-1:0] ch1_gain_word;
   logic [ACR_CAL_W-1:0] ch2_offset_word;
   logic [ACR_CAL_W-1:0] ch2_gain_word;
   logic [ACR_REG_W-1:0] ch2_channel_config;
   acr_input_sel_type ch2_sel;

   // Address decode
   assign req_index = paddr[ACR_ADDR_W-1:2];
   assign req_aligned = (paddr[1:0] == 2'h0);
   assign req_slot = req_index - ACR_IDX_FIRST;
   assign req_hit = req_aligned && (req_index >= ACR_IDX_FIRST)
      && (req_slot < 10'(ACR_NUM_REGS));
   assign setup_phase = psel && !penable;

   // Writes commit at the single access edge, only to mapped words
   assign write_commit = psel && penable && pwrite && state_q.pready
      && !state_q.pslverr;

   // Register storage
   generate
      for (genvar i = 0; i < ACR_NUM_REGS; i++) begin : g_reg
         assign reg_wr_en[i] = write_commit && (req_slot == 10'(i));
         acr_field_reg #(
            .RESET_VALUE(ACR_RST_TABLE[i]),
            .WRITE_MASK(ACR_MASK_TABLE[i])
         ) u_field (
            .pclk(pclk),
            .presetn(presetn),
            .wr_en(reg_wr_en[i]),
            .wr_data(pwdata[ACR_REG_W-1:0]),
            .value(reg_value[i])
         );
      end
   endgenerate

   // Assemble 24-bit trim words from high word and low byte
   assign ch1_offset_word = {reg_value[ACR_SLOT_CH1_OFS_HI],
      reg_value[ACR_SLOT_CH1_OFS_LO][ACR_LOW_FIELD_MSB:ACR_LOW_FIELD_LSB]};
   assign ch1_gain_word = {reg_value[ACR_SLOT_CH1_GAIN_HI],
      reg_value[ACR_SLOT_CH1_GAIN_LO][ACR_LOW_FIELD_MSB:ACR_LOW_FIELD_LSB]};
   assign ch2_offset_word = {reg_value[ACR_SLOT_CH2_OFS_HI],
      reg_value[ACR_SLOT_CH2_OFS_LO][ACR_LOW_FIELD_MSB:ACR_LOW_FIELD_LSB]};
   assign ch2_gain_word = {reg_value[ACR_SLOT_CH2_GAIN_HI],
      reg_value[ACR_SLOT_CH2_GAIN_LO][ACR_LOW_FIELD_MSB:ACR_LOW_FIELD_LSB]};
   assign ch2_channel_config = reg_value[ACR_SLOT_CH2_CHANNEL_CONFIG];
   assign ch2_sel = acr_input_sel_type'(ch2_channel_config[ACR_CFG_SEL_MSB:ACR_CFG_SEL_LSB]);

   // Bus answer and front-end controls
   always_comb begin
      state_d = state_q;
      // Zero-wait slave: ready for exactly the first access cycle
      state_d.pready = setup_phase;
      if (setup_phase) begin
         state_d.pslverr = !req_hit;
         if (req_hit && !pwrite) begin
            // Reserved bits are stored as zero and read back as zero
            state_d.prdata = {16'h0000, reg_value[req_slot[3:0]]};
         end else begin
            state_d.prdata = '0;
         end
      end else if (!psel) begin
         state_d.pslverr = 1'b0;
      end
      state_d.sample_delay = ch2_channel_config[ACR_CFG_DELAY_MSB:ACR_CFG_DELAY_LSB];
      state_d.dc_bypass = ch2_channel_config[ACR_CFG_BYPASS_BIT];
      // Bypass wins, else the global setting decides
      state_d.dc_active = !ch2_channel_config[ACR_CFG_BYPASS_BIT]
         && (global_dc_filter_setting != 4'h0);
      unique case (ch2_sel)
         ACR_SEL_PINS: state_d.input_select = ACR_SEL_PINS;
         ACR_SEL_SHORTED: state_d.input_select = ACR_SEL_SHORTED;
         ACR_SEL_TEST_POS: state_d.input_select = ACR_SEL_TEST_POS;
         ACR_SEL_TEST_NEG: state_d.input_select = ACR_SEL_TEST_NEG;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // Correction pipelines
   acr_trim u_ch1_trim (
      .pclk(pclk),
      .presetn(presetn),
      .offset_word(ch1_offset_word),
      .gain_word(ch1_gain_word),
      .sample_data(ch1_sample_data),
      .sample_valid(ch1_sample_valid),
      .corrected_data(ch1_corrected_data),
      .corrected_valid(ch1_corrected_valid)
   );

   acr_trim u_ch2_trim (
      .pclk(pclk),
      .presetn(presetn),
      .offset_word(ch2_offset_word),
      .gain_word(ch2_gain_word),
      .sample_data(ch2_sample_data),
      .sample_valid(ch2_sample_valid),
      .corrected_data(ch2_corrected_data),
      .corrected_valid(ch2_corrected_valid)
   );

   assign prdata = state_q.prdata;
   assign pready = state_q.pready;
   assign pslverr = state_q.pslverr;
   assign ch2_sample_delay = state_q.sample_delay;
   assign ch2_dc_filter_bypass = state_q.dc_bypass;
   assign ch2_dc_filter_active = state_q.dc_active;
   assign ch2_input_select = state_q.input_select;

endmodule : acr_cal_regs

// ==== core/acr_pkg.sv ====
/*
 * Constants and types for the channel calibration register bank:
 * register indices, reset values, writable masks, field positions and
 * the input selector encoding.
 * Assumes a 32-bit APB slave in front of 16-bit registers.
 */
package acr_pkg;

   // Bus widths
   localparam int ACR_ADDR_W = 12;
   localparam int ACR_DATA_W = 32;
   localparam int ACR_REG_W = 16;
   localparam int ACR_CAL_W = 24;
   localparam int ACR_GAIN_FRAC_W = 23;

   // Register indices; byte address is four times the index
   localparam logic [9:0] ACR_IDX_CH1_OFS_HI = 10'h00F;
   localparam logic [9:0] ACR_IDX_CH1_OFS_LO = 10'h010;
   localparam logic [9:0] ACR_IDX_CH1_GAIN_HI = 10'h011;
   localparam logic [9:0] ACR_IDX_CH1_GAIN_LO = 10'h012;
   localparam logic [9:0] ACR_IDX_CH2_CHANNEL_CONFIG = 10'h013;
   localparam logic [9:0] ACR_IDX_CH2_OFS_HI = 10'h014;
   localparam logic [9:0] ACR_IDX_CH2_OFS_LO = 10'h015;
   localparam logic [9:0] ACR_IDX_CH2_GAIN_HI = 10'h016;
   localparam logic [9:0] ACR_IDX_CH2_GAIN_LO = 10'h017;
   localparam logic [9:0] ACR_IDX_FIRST = ACR_IDX_CH1_OFS_HI;
   localparam int ACR_NUM_REGS = 9;

   // Slot numbers inside the bank, counted from the first index
   localparam int ACR_SLOT_CH1_OFS_HI = 0;
   localparam int ACR_SLOT_CH1_OFS_LO = 1;
   localparam int ACR_SLOT_CH1_GAIN_HI = 2;
   localparam int ACR_SLOT_CH1_GAIN_LO = 3;
   localparam int ACR_SLOT_CH2_CHANNEL_CONFIG = 4;
   localparam int ACR_SLOT_CH2_OFS_HI = 5;
   localparam int ACR_SLOT_CH2_OFS_LO = 6;
   localparam int ACR_SLOT_CH2_GAIN_HI = 7;
   localparam int ACR_SLOT_CH2_GAIN_LO = 8;

   // Reset values
   localparam logic [15:0] ACR_OFS_RST = 16'h0000;
   localparam logic [15:0] ACR_GAIN_HI_RST = 16'h8000;
   localparam logic [15:0] ACR_LOW_RST = 16'h0000;
   localparam logic [15:0] ACR_CFG_RST = 16'h0000;

   // Writable bits
   localparam logic [15:0] ACR_FULL_MASK = 16'hFFFF;
   localparam logic [15:0] ACR_LOW_MASK = 16'hFF00;
   localparam logic [15:0] ACR_CFG_MASK = 16'hFFC7;

   localparam logic [15:0] ACR_RST_TABLE [ACR_NUM_REGS] = '{
      ACR_OFS_RST, ACR_LOW_RST, ACR_GAIN_HI_RST, ACR_LOW_RST, ACR_CFG_RST,
      ACR_OFS_RST, ACR_LOW_RST, ACR_GAIN_HI_RST, ACR_LOW_RST};
   localparam logic [15:0] ACR_MASK_TABLE [ACR_NUM_REGS] = '{
      ACR_FULL_MASK, ACR_LOW_MASK, ACR_FULL_MASK, ACR_LOW_MASK, ACR_CFG_MASK,
      ACR_FULL_MASK, ACR_LOW_MASK, ACR_FULL_MASK, ACR_LOW_MASK};

   // Field positions
   localparam int ACR_LOW_FIELD_MSB = 15;
   localparam int ACR_LOW_FIELD_LSB = 8;
   localparam int ACR_CFG_DELAY_MSB = 15;
   localparam int ACR_CFG_DELAY_LSB = 6;
   localparam int ACR_CFG_BYPASS_BIT = 2;
   localparam int ACR_CFG_SEL_MSB = 1;
   localparam int ACR_CFG_SEL_LSB = 0;

   // Output clamp of the corrected sample
   localparam logic signed [26:0] ACR_SAMPLE_MAX = 27'sh07FFFFF;
   localparam logic signed [26:0] ACR_SAMPLE_MIN = -27'sh0800000;

   typedef enum logic [1:0] {
      ACR_SEL_PINS = 2'b00,
      ACR_SEL_SHORTED = 2'b01,
      ACR_SEL_TEST_POS = 2'b10,
      ACR_SEL_TEST_NEG = 2'b11
   } acr_input_sel_type;

endpackage : acr_pkg

// ==== core/acr_field_reg.sv ====
/*
 * One 16-bit software register with a reset value and a writable mask.
 * Assumes the caller raises wr_en for one cycle at the write's commit edge.
 */
`timescale 1ns/1ps
module acr_field_reg #(
   parameter logic [15:0] RESET_VALUE = 16'h0000,
   parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Write port
   input wire logic wr_en,
   input wire logic [acr_pkg::ACR_REG_W-1:0] wr_data,
   // Stored value
   output logic [acr_pkg::ACR_REG_W-1:0] value
);
   import acr_pkg::*;

   typedef struct packed {
      logic [ACR_REG_W-1:0] value;
   } acr_field_state_type;

   acr_field_state_type state_q;
   acr_field_state_type state_d;

   always_comb begin
      state_d = state_q;
      if (wr_en) begin
         // Bits outside the mask stay zero
         state_d.value = wr_data & WRITE_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= '{value: RESET_VALUE & WRITE_MASK};
      end else begin
         state_q <= state_d;
      end
   end

   assign value = state_q.value;

endmodule : acr_field_reg

// ==== core/acr_trim.sv ====
/*
 * Per-channel correction: adds the signed offset, then scales by the
 * unsigned gain (one at 800000h) and clamps to 24 bits. Two stages.
 * Assumes samples and trim words arrive on pclk.
 */
`timescale 1ns/1ps
module acr_trim (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Trim words
   input wire logic [acr_pkg::ACR_CAL_W-1:0] offset_word,
   input wire logic [acr_pkg::ACR_CAL_W-1:0] gain_word,
   // Raw sample
   input wire logic [acr_pkg::ACR_CAL_W-1:0] sample_data,
   input wire logic sample_valid,
   // Corrected sample
   output logic [acr_pkg::ACR_CAL_W-1:0] corrected_data,
   output logic corrected_valid
);
   import acr_pkg::*;

   typedef struct packed {
      logic signed [ACR_CAL_W:0] sum;
      logic [ACR_CAL_W-1:0] gain;
      logic stage_valid;
      logic [ACR_CAL_W-1:0] out_data;
      logic out_valid;
   } acr_trim_state_type;

   acr_trim_state_type state_q;
   acr_trim_state_type state_d;
   logic signed [2*ACR_CAL_W+1:0] product;
   logic signed [26:0] scaled;

   // Gain is unsigned, so it enters the product with a zero sign bit
   assign product = state_q.sum * $signed({1'b0, state_q.gain});
   assign scaled = product[ACR_GAIN_FRAC_W+26:ACR_GAIN_FRAC_W];

   always_comb begin
      state_d = state_q;
      state_d.stage_valid = sample_valid;
      state_d.out_valid = state_q.stage_valid;
      if (sample_valid) begin
         // Offset first, trim words caught with this sample
         state_d.sum = $signed({sample_data[ACR_CAL_W-1], sample_data})
            + $signed({offset_word[ACR_CAL_W-1], offset_word});
         state_d.gain = gain_word;
      end
      if (state_q.stage_valid) begin
         if (scaled > ACR_SAMPLE_MAX) begin
            state_d.out_data = ACR_SAMPLE_MAX[ACR_CAL_W-1:0];
         end else if (scaled < ACR_SAMPLE_MIN) begin
            state_d.out_data = ACR_SAMPLE_MIN[ACR_CAL_W-1:0];
         end else begin
            state_d.out_data = scaled[ACR_CAL_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign corrected_data = state_q.out_data;
   assign corrected_valid = state_q.out_valid;

endmodule : acr_trim

// ==== bench/acr_cal_regs_checker.sv ====
/* Port checker for the calibration register bank.
   Assumes it is bound to acr_cal_regs and sees only its ports. */
`timescale 1ns/1ps
module acr_cal_regs_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [acr_pkg::ACR_ADDR_W-1:0] paddr,
   input wire logic [acr_pkg::ACR_DATA_W-1:0] pwdata,
   input wire logic [acr_pkg::ACR_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Samples and controls
   input wire logic ch1_sample_valid,
   input wire logic ch1_corrected_valid,
   input wire logic ch2_sample_valid,
   input wire logic ch2_corrected_valid,
   input wire logic [9:0] ch2_sample_delay,
   input wire logic ch2_dc_filter_bypass,
   input wire logic ch2_dc_filter_active,
   input wire logic [1:0] ch2_input_select
);
   import acr_pkg::*;
   logic rd_ok;
   assign rd_ok = pready && !pwrite && !pslverr;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   answer_next_a: assert property (psel && !penable |=> pready && penable)
      else $error("no answer after setup");
   answer_once_a: assert property (pready |=> !pready) else $error("pready held");
   upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   low_reserved_a: assert property (
      rd_ok && paddr inside {12'h040, 12'h048, 12'h054, 12'h05C} |-> prdata[7:0] == 8'h00)
      else $error("reserved low byte set");
   cfg_reserved_a: assert property (rd_ok && paddr == 12'h04C |-> prdata[5:3] == 3'b000)
      else $error("config reserved bits set");
   bad_addr_a: assert property (pready |->
      pslverr == (paddr < 12'h03C || paddr > 12'h05C || paddr[1:0] != 2'b00))
      else $error("error response wrong");
   ch1_latency_a: assert property (ch1_sample_valid |-> ##2 ch1_corrected_valid)
      else $error("ch1 result late");
   ch2_latency_a: assert property (ch2_corrected_valid |-> $past(ch2_sample_valid, 2))
      else $error("ch2 result without sample");
   bypass_excl_a: assert property (ch2_dc_filter_bypass |-> !ch2_dc_filter_active)
      else $error("filter active while bypassed");
   cfg_follow_a: assert property (pready && pwrite && !pslverr && paddr == 12'h04C |->
      ##2 {ch2_sample_delay, ch2_dc_filter_bypass, ch2_input_select} ==
      {$past(pwdata[15:6], 2), $past(pwdata[2], 2), $past(pwdata[1:0], 2)})
      else $error("front-end controls do not follow config");
endmodule : acr_cal_regs_checker

bind acr_cal_regs acr_cal_regs_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .ch1_sample_valid, .ch1_corrected_valid,
   .ch2_sample_valid, .ch2_corrected_valid, .ch2_sample_delay, .ch2_dc_filter_bypass,
   .ch2_dc_filter_active, .ch2_input_select);

// ==== bench/acr_host.sv ====
/* APB host model that issues one transfer per task call.
   Assumes pclk and an APB slave answering with pready. */
`timescale 1ns/1ps
module acr_host (
   // Clock
   input wire logic pclk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [acr_pkg::ACR_ADDR_W-1:0] paddr,
   output logic [acr_pkg::ACR_DATA_W-1:0] pwdata,
   input wire logic [acr_pkg::ACR_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import acr_pkg::*;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'hFFF;
      pwdata = 32'hFFFFFFFF;
   end
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      logic ready;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer only moves on the rising edge, so mid-cycle values hold at it
      do begin
         @(negedge pclk);
         ready = pready;
         rd = prdata;
         err = pslverr;
         @(posedge pclk);
      end while (ready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines stop showing the last value
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : acr_host

// ==== bench/acr_cal_regs_test.sv ====
/* Self-checking bench for the calibration register bank.
   Assumes acr_host as APB master and the bound port checker. */
`timescale 1ns/1ps
module acr_cal_regs_test;
   import acr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] global_dc_filter_setting;
   logic [23:0] ch1_sample_data, ch2_sample_data, ch1_corrected_data, ch2_corrected_data;
   logic ch1_sample_valid, ch2_sample_valid, ch1_corrected_valid, ch2_corrected_valid;
   logic [9:0] ch2_sample_delay;
   logic ch2_dc_filter_bypass, ch2_dc_filter_active;
   logic [1:0] ch2_input_select;
   int failures, cmp_count;
   localparam logic [15:0] MASKS [9] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7,
      16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00};
   localparam logic [15:0] RSTS [9] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h8000, 16'h0000};
   localparam logic [23:0] CASES [5][3] = '{'{24'h000300, 24'h000100, 24'h400000},
      '{24'hFFFFF0, 24'h000000, 24'h800000}, '{24'h7FFFFF, 24'h7FFFFF, 24'hFFFFFF},
      '{24'h800000, 24'hFFFF01, 24'h800000}, '{24'h123456, 24'hFFFF80, 24'h7FFFFF}};
   acr_cal_regs dut (.*);
   acr_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   always #25 pclk = ~pclk;
   task automatic end_of_test;
      $display("Comparisons %0d, failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [11:0] adr(input int i);
      return 12'h03C + 12'(4 * i);
   endfunction : adr
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd, err);
   endtask : wr
   task automatic rdr(input logic [11:0] a);
      host.xfer(1'b0, a, 32'h00000000, rd, err);
   endtask : rdr
   task automatic t_reset;
      for (int i = 0; i < 9; i++) begin
         rdr(adr(i));
         check("reset value", rd, {16'h0000, RSTS[i]});
      end
   endtask : t_reset
   task automatic t_access;
      logic [31:0] pats [2] = '{32'hFFFFFFFF, 32'h5A5AA55A};
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 9; i++) begin
            wr(adr(i), pats[p]);
            rdr(adr(i));
            check("readback", rd, {16'h0000, pats[p][15:0] & MASKS[i]});
         end
      end
      for (int i = 0; i < 9; i++) begin
         wr(adr(i), {16'h0000, RSTS[i]});
      end
   endtask : t_access
   task automatic t_refuse;
      logic [11:0] bad [3] = '{12'h038, 12'h060, 12'h059};
      for (int i = 0; i < 3; i++) begin
         wr(bad[i], 32'h0000FFFF);
         check("write error", {31'h0, err}, 32'h00000001);
         rdr(bad[i]);
         check("read error data", {err, rd[30:0]}, 32'h80000000);
      end
      rdr(12'h058);
      check("untouched gain", rd, 32'h00008000);
   endtask : t_refuse
   task automatic t_cfg;
      logic [15:0] v;
      for (int s = 0; s < 4; s++) begin
         v = {10'h200 + 10'(s), 3'b111, s[0], s[1:0]};
         global_dc_filter_setting <= 4'(s);
         wr(12'h04C, {16'hFFFF, v});
         repeat (3) @(posedge pclk);
         check("delay", {22'h0, ch2_sample_delay}, {22'h0, v[15:6]});
         check("select", {30'h0, ch2_input_select}, 32'(s));
         check("bypass", {31'h0, ch2_dc_filter_bypass}, {31'h0, v[2]});
         check("active", {31'h0, ch2_dc_filter_active}, {31'h0, !v[2] && s != 0});
      end
   endtask : t_cfg
   function automatic logic [23:0] model(input logic [23:0] x, o, g);
      longint s;
      s = (longint'(signed'(x)) + longint'(signed'(o))) * longint'(g);
      s = s >>> 23;
      s = (s > 64'sh7FFFFF) ? 64'sh7FFFFF : ((s < -64'sh800000) ? -64'sh800000 : s);
      return s[23:0];
   endfunction : model
   task automatic t_trim;
      logic [11:0] b;
      int n;
      for (int ch = 1; ch <= 2; ch++) begin
         for (int c = 0; c < 5; c++) begin
            b = (ch == 1) ? 12'h03C : 12'h050;
            wr(b, {16'h0000, CASES[c][1][23:8]});
            wr(b + 12'h004, {16'h0000, CASES[c][1][7:0], 8'h00});
            wr(b + 12'h008, {16'h0000, CASES[c][2][23:8]});
            wr(b + 12'h00C, {16'h0000, CASES[c][2][7:0], 8'h00});
            @(posedge pclk);
            ch1_sample_data <= CASES[c][0];
            ch2_sample_data <= CASES[c][0];
            ch1_sample_valid <= (ch == 1);
            ch2_sample_valid <= (ch == 2);
            @(posedge pclk);
            ch1_sample_valid <= 1'b0;
            ch2_sample_valid <= 1'b0;
            n = 0;
            do begin
               @(negedge pclk);
               n++;
            end while (((ch == 1) ? ch1_corrected_valid : ch2_corrected_valid) !== 1'b1 && n < 8);
            check("valid", {31'h0, (ch == 1) ? ch1_corrected_valid : ch2_corrected_valid},
               32'h00000001);
            check("corrected", {8'h00, (ch == 1) ? ch1_corrected_data : ch2_corrected_data},
               {8'h00, model(CASES[c][0], CASES[c][1], CASES[c][2])});
         end
      end
   endtask : t_trim
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      global_dc_filter_setting = 4'h0;
      ch1_sample_data = 24'h000000;
      ch2_sample_data = 24'h000000;
      ch1_sample_valid = 1'b0;
      ch2_sample_valid = 1'b0;
      failures = 0;
      cmp_count = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_access();
      t_refuse();
      t_cfg();
      t_trim();
      end_of_test();
   end
   initial begin
      #(50 * 5000);
      failures++;
      end_of_test();
   end
endmodule : acr_cal_regs_test
